// *** logic/dgp_pkg.sv ***
// constants and register map of the dual port pin multiplexer
//----------------------------------------------------------------------
// Overview of operation
// - two ports of eight pins, each pin individually input or output
// - direction bit one tri-states the pin driver, pin is an input
// - direction bit zero drives the pin from its output latch bit
// - output latch reads return stored latch data, not pin levels
// - enabled peripherals may force a pin to output or to input
// - overrides reach only the pin; direction register keeps software value
// - every reset sets all direction bits to one, pins come up inputs
// - channel 2 pin select at one puts channel 2 on port two bit 1
// - pin select clear with alt mode set moves channel 2 to alternate pin, port one bit 3 here
// - port one bits 0 to 3 are external interrupt lines 0 to 3
// - port one bits 4 to 7 provide interrupt-on-change
// - every port one pin has a software switched weak pull-up
// - port one bits 5,6,7 are low-volt enable, programming clock and data
// - port one bit 3 carries channel 2 capture, compare, pwm or pwm a
// - port two bit 0 timer1 osc out or timer clock in; bit 1 osc in
// - port two bit 2 carries channel 1 capture, compare, pwm or pwm a
// - port two bit 3 serial clock; bit 4 serial data in or i2c data
// - port two bit 5 is serial port data output
// - port two bit 6 usart transmit or clock; bit 7 receive or data
// - active-low control turns all port one pull-ups on, off on outputs
// - input mismatch on bits 4-7 versus last read or write keeps setting change flag
//----------------------------------------------------------------------
package dgp_pkg;
    localparam int          WIDTH          = 8;
    localparam logic [3:0]  ADDR_P1_PINS   = 4'h0;
    localparam logic [3:0]  ADDR_P1_LATCH  = 4'h1;
    localparam logic [3:0]  ADDR_P1_DIR    = 4'h2;
    localparam logic [3:0]  ADDR_P2_PINS   = 4'h3;
    localparam logic [3:0]  ADDR_P2_LATCH  = 4'h4;
    localparam logic [3:0]  ADDR_P2_DIR    = 4'h5;
    localparam logic [3:0]  ADDR_INT_MAIN  = 4'h6;
    localparam logic [3:0]  ADDR_INT_EDGE  = 4'h7;
    localparam logic [3:0]  ADDR_INT_EXT   = 4'h8;
    localparam logic [7:0]  DIR_RESET      = 8'hff;
    localparam logic [7:0]  LATCH_RESET    = 8'h00;
    localparam logic [7:0]  INT_MAIN_RESET = 8'h00;
    localparam logic [7:0]  INT_EDGE_RESET = 8'hff;
    localparam logic [7:0]  INT_EXT_RESET  = 8'hc0;
    localparam int          PULLUP_BIT     = 7;
    localparam int          CHANGE_FLAG_BIT = 0;
    localparam int          P1_CAPTURE_COMPARE_CHANNEL_2_BIT    = 3;
    localparam int          P2_CAPTURE_COMPARE_CHANNEL_2_BIT    = 1;
    localparam logic [7:0]  CHANGE_MASK    = 8'hf0;
endpackage : dgp_pkg

// *** logic/dgp_sync.sv ***
// three-stage pin synchroniser, one per bit
`timescale 1ns/10ps
module dgp_sync (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // data
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);
    logic [7:0] s1_reg;
    logic [7:0] s2_reg;
    logic [7:0] s3_reg;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    s1_reg[g]   <= 1'b0;
                    s2_reg[g]   <= 1'b0;
                    s3_reg[g]   <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    s1_reg[g] <= async_in[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    // a change counts once the second and third stages agree
                    if (s2_reg[g] == s3_reg[g]) begin
                        sync_out[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate
endmodule : dgp_sync

// *** logic/dgp_port.sv ***
// two 8-bit general purpose ports with peripheral pin multiplexing
`timescale 1ns/10ps
module dgp_port (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // register port
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // configuration straps
    input  wire logic       channel2_pin_select_in,
    input  wire logic       alt_mode_in,
    // port one pins
    input  wire logic [7:0] p1_pin_in,
    output logic      [7:0] p1_pin_out,
    output logic      [7:0] p1_pin_oe_out,
    output logic      [7:0] p1_pullup_out,
    // port two pins
    input  wire logic [7:0] p2_pin_in,
    output logic      [7:0] p2_pin_out,
    output logic      [7:0] p2_pin_oe_out,
    // peripheral overrides on port two: force-output, force-input, data
    input  wire logic [7:0] p2_periph_out_en_in,
    input  wire logic [7:0] p2_periph_in_en_in,
    input  wire logic [7:0] p2_periph_data_in,
    // channel 2 peripheral on its selected pin
    input  wire logic       capture_compare_channel_2_out_en_in,
    input  wire logic       capture_compare_channel_2_data_in,
    output logic            capture_compare_channel_2_in_out,
    // peripheral inputs taken from pins
    output logic      [3:0] ext_irq_line_out,
    output logic      [3:0] change_irq_line_out,
    output logic      [2:0] serial_prog_out,
    output logic      [7:0] p2_periph_in_out,
    output logic            port_change_flag_out
);
    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [7:0] p1_latch_reg;
    logic [7:0] p1_dir_reg;
    logic [7:0] p2_latch_reg;
    logic [7:0] p2_dir_reg;
    logic [7:0] int_main_reg;
    logic [7:0] int_edge_reg;
    logic [7:0] int_ext_reg;
    logic [7:0] change_ref_reg;
    logic [7:0] p1_sync;
    logic [7:0] p2_sync;
    logic       capture_compare_channel_2_on_p2;
    logic       capture_compare_channel_2_on_p1;
    logic [7:0] p1_oe_next;
    logic [7:0] p1_out_next;
    logic [7:0] p2_oe_next;
    logic [7:0] p2_out_next;
    logic [7:0] p1_level;
    logic [7:0] p2_level;
    logic       mismatch;
    logic       p1_touch;

    dgp_sync u_sync1 (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in (p1_pin_in),
        .sync_out (p1_sync)
    );

    dgp_sync u_sync2 (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in (p2_pin_in),
        .sync_out (p2_sync)
    );

    //------------------------------------------------------------------
    // software registers
    //------------------------------------------------------------------
    // writes to the pin data address land in the latch, as in the usual
    // port model where a port write updates the output latch
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            p1_latch_reg <= dgp_pkg::LATCH_RESET;
            p2_latch_reg <= dgp_pkg::LATCH_RESET;
        end else if (wr_in) begin
            if (addr_in == dgp_pkg::ADDR_P1_PINS || addr_in == dgp_pkg::ADDR_P1_LATCH) begin
                p1_latch_reg <= wdata_in;
            end
            if (addr_in == dgp_pkg::ADDR_P2_PINS || addr_in == dgp_pkg::ADDR_P2_LATCH) begin
                p2_latch_reg <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            p1_dir_reg <= dgp_pkg::DIR_RESET;
            p2_dir_reg <= dgp_pkg::DIR_RESET;
        end else if (wr_in) begin
            if (addr_in == dgp_pkg::ADDR_P1_DIR) begin
                p1_dir_reg <= wdata_in;
            end
            if (addr_in == dgp_pkg::ADDR_P2_DIR) begin
                p2_dir_reg <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_edge_reg <= dgp_pkg::INT_EDGE_RESET;
            int_ext_reg  <= dgp_pkg::INT_EXT_RESET;
        end else if (wr_in) begin
            if (addr_in == dgp_pkg::ADDR_INT_EDGE) begin
                int_edge_reg <= wdata_in;
            end
            if (addr_in == dgp_pkg::ADDR_INT_EXT) begin
                int_ext_reg <= wdata_in;
            end
        end
    end

    //------------------------------------------------------------------
    // interrupt-on-change
    //------------------------------------------------------------------
    // reference is taken at every read or write of port one pin data
    assign p1_touch = (rd_in || wr_in) && addr_in == dgp_pkg::ADDR_P1_PINS;
    assign mismatch = |((p1_sync ^ change_ref_reg) & p1_dir_reg & dgp_pkg::CHANGE_MASK);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            change_ref_reg <= 8'h00;
        end else if (p1_touch) begin
            change_ref_reg <= p1_sync;
        end
    end

    // set beats a software clear, so a mismatch during the clear is kept
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_main_reg <= dgp_pkg::INT_MAIN_RESET;
        end else begin
            if (wr_in && addr_in == dgp_pkg::ADDR_INT_MAIN) begin
                int_main_reg <= wdata_in;
            end
            if (mismatch) begin
                int_main_reg[dgp_pkg::CHANGE_FLAG_BIT] <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // pin multiplexing
    //------------------------------------------------------------------
    assign capture_compare_channel_2_on_p2 = channel2_pin_select_in;
    assign capture_compare_channel_2_on_p1 = !channel2_pin_select_in && alt_mode_in;

    always_comb begin
        p1_oe_next  = ~p1_dir_reg;
        p1_out_next = p1_latch_reg;
        if (capture_compare_channel_2_on_p1 && capture_compare_channel_2_out_en_in) begin
            p1_oe_next[dgp_pkg::P1_CAPTURE_COMPARE_CHANNEL_2_BIT]  = 1'b1;
            p1_out_next[dgp_pkg::P1_CAPTURE_COMPARE_CHANNEL_2_BIT] = capture_compare_channel_2_data_in;
        end
        // override acts on the pin; direction register is left alone
        p2_oe_next  = (~p2_dir_reg | p2_periph_out_en_in) & ~p2_periph_in_en_in;
        p2_out_next = (p2_latch_reg & ~p2_periph_out_en_in) | (p2_periph_data_in & p2_periph_out_en_in);
        if (capture_compare_channel_2_on_p2 && capture_compare_channel_2_out_en_in) begin
            p2_oe_next[dgp_pkg::P2_CAPTURE_COMPARE_CHANNEL_2_BIT]  = 1'b1;
            p2_out_next[dgp_pkg::P2_CAPTURE_COMPARE_CHANNEL_2_BIT] = capture_compare_channel_2_data_in;
        end
    end

    // readback of pin levels: driven pins show what is driven
    assign p1_level = (p1_sync & ~p1_pin_oe_out) | (p1_pin_out & p1_pin_oe_out);
    assign p2_level = (p2_sync & ~p2_pin_oe_out) | (p2_pin_out & p2_pin_oe_out);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            p1_pin_out    <= 8'h00;
            p1_pin_oe_out <= 8'h00;
            p2_pin_out    <= 8'h00;
            p2_pin_oe_out <= 8'h00;
            p1_pullup_out <= 8'h00;
        end else begin
            p1_pin_out    <= p1_out_next;
            p1_pin_oe_out <= p1_oe_next;
            p2_pin_out    <= p2_out_next;
            p2_pin_oe_out <= p2_oe_next;
            // one active-low bit enables all pull-ups, dropped on outputs
            p1_pullup_out <= int_edge_reg[dgp_pkg::PULLUP_BIT] ? 8'h00 : ~p1_oe_next;
        end
    end

    //------------------------------------------------------------------
    // peripheral inputs
    //------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_irq_line_out     <= 4'h0;
            change_irq_line_out  <= 4'h0;
            serial_prog_out      <= 3'h0;
            p2_periph_in_out     <= 8'h00;
            capture_compare_channel_2_in_out          <= 1'b0;
            port_change_flag_out <= 1'b0;
        end else begin
            ext_irq_line_out     <= p1_sync[3:0];
            change_irq_line_out  <= p1_sync[7:4];
            serial_prog_out      <= p1_sync[7:5];
            // bits: 0 timer clock, 1 osc in, 2 ch1, 3 sck, 4 sdi, 5 sdo, 6 tx/ck, 7 rx/dt
            p2_periph_in_out     <= p2_sync;
            capture_compare_channel_2_in_out          <= capture_compare_channel_2_on_p1 ? p1_sync[dgp_pkg::P1_CAPTURE_COMPARE_CHANNEL_2_BIT]
                                               : p2_sync[dgp_pkg::P2_CAPTURE_COMPARE_CHANNEL_2_BIT];
            port_change_flag_out <= int_main_reg[dgp_pkg::CHANGE_FLAG_BIT];
        end
    end

    //------------------------------------------------------------------
    // read port
    //------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                dgp_pkg::ADDR_P1_PINS:  rdata_out <= p1_level;
                dgp_pkg::ADDR_P1_LATCH: rdata_out <= p1_latch_reg;
                dgp_pkg::ADDR_P1_DIR:   rdata_out <= p1_dir_reg;
                dgp_pkg::ADDR_P2_PINS:  rdata_out <= p2_level;
                dgp_pkg::ADDR_P2_LATCH: rdata_out <= p2_latch_reg;
                dgp_pkg::ADDR_P2_DIR:   rdata_out <= p2_dir_reg;
                dgp_pkg::ADDR_INT_MAIN: rdata_out <= int_main_reg;
                dgp_pkg::ADDR_INT_EDGE: rdata_out <= int_edge_reg;
                dgp_pkg::ADDR_INT_EXT:  rdata_out <= int_ext_reg;
                default:                rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    //------------------------------------------------------------------
    // check sequences
    //------------------------------------------------------------------
    // software writes to the registers that the pins depend on
    sequence p1_dir_write_s;
        wr_in && addr_in == dgp_pkg::ADDR_P1_DIR;
    endsequence
    sequence p2_dir_write_s;
        wr_in && addr_in == dgp_pkg::ADDR_P2_DIR;
    endsequence
    sequence p1_latch_write_s;
        wr_in && (addr_in == dgp_pkg::ADDR_P1_PINS || addr_in == dgp_pkg::ADDR_P1_LATCH);
    endsequence
    // a mismatch reaches the flag bit, then the registered flag output
    sequence change_seen_s;
        mismatch;
    endsequence
    sequence flag_shown_s;
        int_main_reg[dgp_pkg::CHANGE_FLAG_BIT] ##1 port_change_flag_out;
    endsequence
    // channel 2 driving, on whichever pin the straps select
    sequence capture_compare_channel_2_default_s;
        channel2_pin_select_in && capture_compare_channel_2_out_en_in;
    endsequence
    sequence capture_compare_channel_2_alt_s;
        !channel2_pin_select_in && alt_mode_in && capture_compare_channel_2_out_en_in;
    endsequence

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    // direction and drive
    dir_reset_a: assert property (@(posedge clk_in) $fell(reset_in) |->
        p1_dir_reg == dgp_pkg::DIR_RESET && p2_dir_reg == dgp_pkg::DIR_RESET)
        else $error("direction not all ones after reset");
    tristate_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) && $past(p1_dir_reg[0]) |-> !p1_pin_oe_out[0])
        else $error("input pin is driven");
    drive_latch_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) && !$past(p1_dir_reg[0])
        |-> p1_pin_oe_out[0] && p1_pin_out[0] == $past(p1_latch_reg[0]))
        else $error("output pin not driven from latch");
    p1_dir_wr_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p1_dir_write_s |=> p1_dir_reg == $past(wdata_in))
        else $error("port one direction write lost");
    p2_dir_wr_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p2_dir_write_s |=> p2_dir_reg == $past(wdata_in))
        else $error("port two direction write lost");
    p1_latch_wr_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p1_latch_write_s |=> p1_latch_reg == $past(wdata_in))
        else $error("port one latch write lost");

    // register reads
    latch_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_in && addr_in == dgp_pkg::ADDR_P2_LATCH |=> rdata_out == $past(p2_latch_reg))
        else $error("latch read wrong");
    p1_latch_rd_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_in && addr_in == dgp_pkg::ADDR_P1_LATCH |=> rdata_out == $past(p1_latch_reg))
        else $error("port one latch read wrong");
    dir_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_in && addr_in == dgp_pkg::ADDR_P2_DIR |=> rdata_out == $past(p2_dir_reg))
        else $error("direction read wrong");
    pin_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_in && addr_in == dgp_pkg::ADDR_P2_PINS
        |=> (rdata_out & ~$past(p2_pin_oe_out)) == ($past(p2_sync) & ~$past(p2_pin_oe_out)))
        else $error("input pin level read wrong");

    // peripheral overrides
    override_pin_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p2_periph_in_en_in[7] ##1 !reset_in |-> !p2_pin_oe_out[7])
        else $error("forced input pin driven");
    force_out_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p2_periph_out_en_in[0] && !p2_periph_in_en_in[0]
        |=> p2_pin_oe_out[0] && p2_pin_out[0] == $past(p2_periph_data_in[0]))
        else $error("forced output pin not driven");
    p2_tristate_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p2_dir_reg[0] && !p2_periph_out_en_in[0] |=> !p2_pin_oe_out[0])
        else $error("port two input pin is driven");
    dir_keep_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !(wr_in && addr_in == dgp_pkg::ADDR_P2_DIR) |=> $stable(p2_dir_reg))
        else $error("direction changed without write");
    capture_compare_channel_2_default_a: assert property (@(posedge clk_in) disable iff (reset_in)
        capture_compare_channel_2_default_s
        |=> p2_pin_oe_out[dgp_pkg::P2_CAPTURE_COMPARE_CHANNEL_2_BIT] && p2_pin_out[dgp_pkg::P2_CAPTURE_COMPARE_CHANNEL_2_BIT] == $past(capture_compare_channel_2_data_in))
        else $error("channel 2 not on its default pin");
    capture_compare_channel_2_alt_a: assert property (@(posedge clk_in) disable iff (reset_in)
        capture_compare_channel_2_alt_s
        |=> p1_pin_oe_out[dgp_pkg::P1_CAPTURE_COMPARE_CHANNEL_2_BIT] && p1_pin_out[dgp_pkg::P1_CAPTURE_COMPARE_CHANNEL_2_BIT] == $past(capture_compare_channel_2_data_in))
        else $error("channel 2 not on its alternate pin");

    // pull-ups and change detection
    pullup_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        |(p1_pullup_out & p1_pin_oe_out) == 1'b0)
        else $error("pull-up on a driven pin");
    pullup_on_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !int_edge_reg[dgp_pkg::PULLUP_BIT] |=> p1_pullup_out == ~p1_pin_oe_out)
        else $error("pull-ups not on for inputs");
    change_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
        change_seen_s |=> flag_shown_s)
        else $error("change flag not set");
    flag_quiet_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !mismatch && !int_main_reg[dgp_pkg::CHANGE_FLAG_BIT] && !(wr_in && addr_in == dgp_pkg::ADDR_INT_MAIN)
        |=> !int_main_reg[dgp_pkg::CHANGE_FLAG_BIT])
        else $error("change flag set without mismatch");
    ref_update_a: assert property (@(posedge clk_in) disable iff (reset_in)
        p1_touch |=> change_ref_reg == $past(p1_sync))
        else $error("change reference not taken");
endmodule : dgp_port

// *** bench/dgp_pin_model.sv ***
// pad model of the pins and of whatever drives them from outside
`timescale 1ns/10ps
module dgp_pin_model (
    // clock
    input  wire logic       clk_in,
    // from the design
    input  wire logic [7:0] oe_in,
    input  wire logic [7:0] dout_in,
    input  wire logic [7:0] pull_in,
    // outside driver
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    // pad level
    output logic      [7:0] level_out
);
    logic [7:0] float_reg = 8'h5a;
    // a line with nobody on it wanders, so reading it cannot pass by luck
    always @(posedge clk_in) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        level_out = (oe_in & dout_in) | (~oe_in & ext_en_in & ext_val_in)
                  | (~oe_in & ~ext_en_in & (pull_in | float_reg));
    end
endmodule : dgp_pin_model

// *** bench/testbench.sv ***
// self-checking bench for the dual port pin multiplexer
`timescale 1ns/10ps
module testbench;
    logic clk_in, reset_in, wr, rd, sel, alt, c2_oe, c2_d, c2_in, flag;
    logic [3:0] addr, ext_irq, chg_irq;
    logic [2:0] sprog;
    logic [7:0] wdata, rdata, p1_in, p1_out, p1_oe, p1_pu, p2_in, p2_out, p2_oe, p2_oen, p2_ien, p2_pd, p2_pin;
    logic [7:0] ext1_en, ext1_v, ext2_v, l1, d1, x1, l2, d2, x2, oen, ien, pd, e2, o2, v1, v2;
    logic [31:0] seed;
    int err_total, cmp_count, cyc;

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    dgp_port u_dgp_port (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .channel2_pin_select_in(sel), .alt_mode_in(alt), .p1_pin_in(p1_in),
        .p1_pin_out(p1_out), .p1_pin_oe_out(p1_oe), .p1_pullup_out(p1_pu), .p2_pin_in(p2_in),
        .p2_pin_out(p2_out), .p2_pin_oe_out(p2_oe), .p2_periph_out_en_in(p2_oen), .p2_periph_in_en_in(p2_ien),
        .p2_periph_data_in(p2_pd), .capture_compare_channel_2_out_en_in(c2_oe), .capture_compare_channel_2_data_in(c2_d), .capture_compare_channel_2_in_out(c2_in),
        .ext_irq_line_out(ext_irq), .change_irq_line_out(chg_irq), .serial_prog_out(sprog),
        .p2_periph_in_out(p2_pin), .port_change_flag_out(flag));
    dgp_pin_model u_pins_one (.clk_in(clk_in), .oe_in(p1_oe), .dout_in(p1_out), .pull_in(p1_pu),
        .ext_en_in(ext1_en), .ext_val_in(ext1_v), .level_out(p1_in));
    dgp_pin_model u_pins_two (.clk_in(clk_in), .oe_in(p2_oe), .dout_in(p2_out), .pull_in(8'h00),
        .ext_en_in(8'hff), .ext_val_in(ext2_v), .level_out(p2_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] lvl(input logic [7:0] oe, input logic [7:0] dout, input logic [7:0] ext);
        return (oe & dout) | (~oe & ext);
    endfunction : lvl

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk(name, rdata & m, exp);
    endtask : rd_chk
    task automatic look(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : look
    task automatic do_reset;
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
    endtask : do_reset
    task automatic reset_chk;
        rd_chk("p1 dir", dgp_pkg::ADDR_P1_DIR, 8'hff, 8'hff);
        rd_chk("p2 dir", dgp_pkg::ADDR_P2_DIR, 8'hff, 8'hff);
        rd_chk("int main", dgp_pkg::ADDR_INT_MAIN, 8'h00, 8'hff);
        rd_chk("int edge", dgp_pkg::ADDR_INT_EDGE, 8'hff, 8'hff);
        rd_chk("int ext", dgp_pkg::ADDR_INT_EXT, 8'hc0, 8'hff);
        rd_chk("unmapped", 4'hc, 8'h00, 8'hff);
        chk("oe", p1_oe | p2_oe | p1_pu, 8'h00);
    endtask : reset_chk
    task automatic tally_and_finish;
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ceiling is about thirty times the expected run length
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        {reset_in, wr, rd, sel, alt, c2_oe, c2_d} = 7'h41;
        {addr, wdata, p2_oen, p2_ien, p2_pd, ext1_v, ext2_v} = '0;
        ext1_en = 8'hff;
        seed = 32'h5c63;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        reset_chk();
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed); {x1, d1, l1} = seed[23:0];
            seed = lfsr(seed); {x2, d2, l2} = seed[23:0];
            seed = lfsr(seed); {pd, oen} = seed[15:0]; ien = seed[23:16] & seed[31:24];
            @(posedge clk_in);
            {ext1_v, ext2_v, p2_oen, p2_ien, p2_pd} <= {x1, x2, oen, ien, pd};
            reg_wr(seed[0] ? dgp_pkg::ADDR_P1_PINS : dgp_pkg::ADDR_P1_LATCH, l1);
            reg_wr(dgp_pkg::ADDR_P1_DIR, d1);
            reg_wr(dgp_pkg::ADDR_P2_LATCH, l2);
            reg_wr(dgp_pkg::ADDR_P2_DIR, d2);
            look(6);
            e2 = (~d2 | oen) & ~ien;
            o2 = (oen & pd) | (~oen & l2);
            v1 = lvl(~d1, l1, x1);
            v2 = lvl(e2, o2, x2);
            chk("p1 oe", p1_oe, ~d1);
            chk("p1 out", p1_out & ~d1, l1 & ~d1);
            chk("p2 oe", p2_oe, e2);
            chk("p2 out", p2_out & e2, o2 & e2);
            chk("irq lines", {chg_irq, ext_irq}, v1);
            chk("prog lines", {5'h00, sprog}, {5'h00, v1[7:5]});
            chk("p2 periph in", p2_pin, v2);
            rd_chk("p1 latch", dgp_pkg::ADDR_P1_LATCH, l1, 8'hff);
            rd_chk("p2 latch", dgp_pkg::ADDR_P2_LATCH, l2, 8'hff);
            rd_chk("p1 dir", dgp_pkg::ADDR_P1_DIR, d1, 8'hff);
            rd_chk("p2 dir", dgp_pkg::ADDR_P2_DIR, d2, 8'hff);
            rd_chk("p1 pins", dgp_pkg::ADDR_P1_PINS, v1, 8'hff);
            rd_chk("p2 pins", dgp_pkg::ADDR_P2_PINS, v2, 8'hff);
        end
        // pull-ups: floating inputs read high while enabled, pull-up outputs drop when disabled
        @(posedge clk_in);
        {ext1_en, p2_oen, p2_ien} <= '0;
        reg_wr(dgp_pkg::ADDR_P1_LATCH, 8'h0c);
        reg_wr(dgp_pkg::ADDR_P1_DIR, 8'h33);
        reg_wr(dgp_pkg::ADDR_INT_EDGE, 8'h7f);
        look(6);
        chk("pull on", p1_pu, 8'h33);
        rd_chk("pulled pins", dgp_pkg::ADDR_P1_PINS, 8'h3f, 8'hff);
        reg_wr(dgp_pkg::ADDR_INT_EDGE, 8'hff);
        look(2);
        chk("pull off", p1_pu, 8'h00);
        // change flag from a change on bit 6
        @(posedge clk_in);
        {ext1_en, ext1_v} <= 16'hff00;
        reg_wr(dgp_pkg::ADDR_P1_DIR, 8'hf0);
        look(6);
        rd_chk("ref read", dgp_pkg::ADDR_P1_PINS, 8'h00, 8'hf0);
        reg_wr(dgp_pkg::ADDR_INT_MAIN, 8'h00);
        look(2);
        chk("flag idle", {7'h00, flag}, 8'h00);
        ext1_v <= 8'h40;
        look(6);
        chk("flag set", {7'h00, flag}, 8'h01);
        reg_wr(dgp_pkg::ADDR_INT_MAIN, 8'h00);
        rd_chk("flag held", dgp_pkg::ADDR_INT_MAIN, 8'h01, 8'h01);
        rd_chk("end mismatch", dgp_pkg::ADDR_P1_PINS, 8'h40, 8'hf0);
        reg_wr(dgp_pkg::ADDR_INT_MAIN, 8'h00);
        rd_chk("flag clear", dgp_pkg::ADDR_INT_MAIN, 8'h00, 8'h01);
        // channel 2 pin selection: default, alternate, off-block
        reg_wr(dgp_pkg::ADDR_P1_DIR, 8'hff);
        reg_wr(dgp_pkg::ADDR_P2_DIR, 8'hff);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_in);
            {sel, alt, c2_oe, c2_d, ext1_v, ext2_v} <= {m == 0, m == 1, 2'b11, 16'h0000};
            look(6);
            chk("capture_compare_channel_2 p1 oe", p1_oe, (m == 1) ? 8'h08 : 8'h00);
            chk("capture_compare_channel_2 p2 oe", p2_oe, (m == 0) ? 8'h02 : 8'h00);
            chk("capture_compare_channel_2 data", {6'h00, p1_out[3] & p1_oe[3], p2_out[1] & p2_oe[1]}, {6'h00, m == 1, m == 0});
            {c2_oe, ext1_v, ext2_v} <= {1'b0, 16'h0802};
            look(6);
            if (m < 2) chk("capture_compare_channel_2 in", {7'h00, c2_in}, 8'h01);
        end
        // reset in mid-run returns every pin to input
        reg_wr(dgp_pkg::ADDR_P2_DIR, 8'h00);
        do_reset();
        reset_chk();
        tally_and_finish();
    end
endmodule : testbench
